// ===== core/hfo_clock_select.v
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`include "hfo_consts.vh"
module hfo_clock_select #(
  parameter [`HFO_TRIM_W-1:0] TRIM_FACTORY = `HFO_TRIM_RESET,
  parameter                   SETTLE_NS    = `HFO_SETTLE_NS
) (
  // clock and reset
  input  wire       CLK,
  input  wire       RST_N,
  // register port
  input  wire [7:0] ADDR,
  input  wire [7:0] WR_DATA,
  input  wire       WR_EN,
  input  wire       RD_EN,
  output reg  [7:0] RD_DATA,
  // clock source pins
  input  wire       LF_OSC_IN,
  input  wire       EXT_OSC_IN,
  input  wire       MULT_IN,
  // wake sources
  input  wire       USB_RESUME,
  input  wire       VBUS,
  input  wire       VBUS_POLARITY_SEL,
  // clock enables and status
  output reg        CORE_CLK_EN,
  output reg        USB_CLK_EN,
  output reg        HF_OSC_RUN
);

  localparam integer SETTLE_CYC_RAW = (SETTLE_NS + `HFO_CLK_NS - 1) / `HFO_CLK_NS;
  localparam integer SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam [11:0]  SETTLE_LAST    = SETTLE_CYC[11:0] - 12'h001;
  // reset image of the control register, so its enable bit is picked by position
  localparam [7:0]   CTRL_RESET     = `HFO_CTRL_RESET;

  localparam [1:0] ST_OFF    = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_RUN    = 2'h2;
  localparam [1:0] ST_SUSP   = 2'h3;

  // reset release
  reg rst_meta;
  reg rst_n;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // synchronised pins
  wire lf_s;
  wire ext_s;
  wire mult_s;
  wire resume_s;
  wire vbus_s;

  hfo_sync u_sync_lf (
    .clk   (CLK),
    .rst_n (rst_n),
    .din   (LF_OSC_IN),
    .dout  (lf_s)
  );

  hfo_sync u_sync_ext (
    .clk   (CLK),
    .rst_n (rst_n),
    .din   (EXT_OSC_IN),
    .dout  (ext_s)
  );

  hfo_sync u_sync_mult (
    .clk   (CLK),
    .rst_n (rst_n),
    .din   (MULT_IN),
    .dout  (mult_s)
  );

  hfo_sync u_sync_resume (
    .clk   (CLK),
    .rst_n (rst_n),
    .din   (USB_RESUME),
    .dout  (resume_s)
  );

  hfo_sync u_sync_vbus (
    .clk   (CLK),
    .rst_n (rst_n),
    .din   (VBUS),
    .dout  (vbus_s)
  );

  // rising edges of the external clock sources
  reg lf_d;
  reg ext_d;
  reg mult_d;

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lf_d   <= 1'b0;
      ext_d  <= 1'b0;
      mult_d <= 1'b0;
    end else begin
      lf_d   <= lf_s;
      ext_d  <= ext_s;
      mult_d <= mult_s;
    end
  end

  wire lf_tick;
  wire ext_tick;
  wire mult_tick;

  assign lf_tick   = lf_s & ~lf_d;
  assign ext_tick  = ext_s & ~ext_d;
  assign mult_tick = mult_s & ~mult_d;

  // register decode
  wire wr_ctrl;
  wire wr_trim;
  wire wr_csel;

  assign wr_ctrl = WR_EN & (ADDR == `HFO_ADDR_CTRL);
  assign wr_trim = WR_EN & (ADDR == `HFO_ADDR_TRIM);
  assign wr_csel = WR_EN & (ADDR == `HFO_ADDR_CSEL);

  // software state
  reg                   osc_en;
  reg [1:0]             div_sel;
  reg [`HFO_TRIM_W-1:0] trim;
  reg [1:0]             core_src;
  reg [1:0]             usb_src;

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      osc_en   <= CTRL_RESET[`HFO_CTRL_EN];
      div_sel  <= `HFO_DIV8;
      trim     <= TRIM_FACTORY;
      core_src <= `HFO_CORE_HF;
      usb_src  <= `HFO_USB_HF;
    end else begin
      if (wr_ctrl) begin
        osc_en  <= WR_DATA[`HFO_CTRL_EN];
        div_sel <= WR_DATA[`HFO_CTRL_DIV_HI:`HFO_CTRL_DIV_LO];
      end
      if (wr_trim) begin
        trim <= WR_DATA[`HFO_TRIM_W-1:0];
      end
      if (wr_csel) begin
        core_src <= WR_DATA[`HFO_CSEL_CORE_HI:`HFO_CSEL_CORE_LO];
        usb_src  <= WR_DATA[`HFO_CSEL_USB_HI:`HFO_CSEL_USB_LO];
      end
    end
  end

  // oscillator state machine
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [11:0] settle_cnt;
  wire        susp_req;
  wire        wake;
  wire        en_now;

  assign susp_req = wr_ctrl & WR_DATA[`HFO_CTRL_SUSP];
  // resume detection is not gated by transceiver enable
  assign wake     = resume_s | (vbus_s == VBUS_POLARITY_SEL);
  // a write that clears the enable wins over suspend in the same cycle
  assign en_now   = wr_ctrl ? WR_DATA[`HFO_CTRL_EN] : osc_en;

  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (en_now) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!en_now) begin
          next_state = ST_OFF;
        end else if (susp_req) begin
          next_state = ST_SUSP;
        end else if (!wr_trim && settle_cnt == SETTLE_LAST) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!en_now) begin
          next_state = ST_OFF;
        end else if (susp_req) begin
          next_state = ST_SUSP;
        end else if (wr_trim) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SUSP: begin
        if (!en_now) begin
          next_state = ST_OFF;
        end else if (wake) begin
          next_state = ST_SETTLE;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_OFF;
      settle_cnt <= 12'h000;
    end else begin
      state <= next_state;
      if (next_state != ST_SETTLE || state != ST_SETTLE || wr_trim) begin
        settle_cnt <= 12'h000;
      end else begin
        settle_cnt <= settle_cnt + 12'h001;
      end
    end
  end

  // oscillator period model, one tick every trim+1 cycles
  reg  [`HFO_TRIM_W-1:0] period_cnt;
  reg                    hf_tick;
  wire                   osc_on;

  assign osc_on = (state == ST_SETTLE) | (state == ST_RUN);

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= {`HFO_TRIM_W{1'b0}};
      hf_tick    <= 1'b0;
    end else if (!osc_on) begin
      period_cnt <= {`HFO_TRIM_W{1'b0}};
      hf_tick    <= 1'b0;
    end else if (period_cnt >= trim) begin
      period_cnt <= {`HFO_TRIM_W{1'b0}};
      hf_tick    <= (state == ST_RUN);
    end else begin
      period_cnt <= period_cnt + {{(`HFO_TRIM_W-1){1'b0}}, 1'b1};
      hf_tick    <= 1'b0;
    end
  end

  // dividers
  wire hf_div_tick;
  wire mult_half_tick;

  hfo_divider u_div_hf (
    .clk      (CLK),
    .rst_n    (rst_n),
    .tick_in  (hf_tick),
    .sel      (div_sel),
    .tick_out (hf_div_tick)
  );

  hfo_divider u_div_mult (
    .clk      (CLK),
    .rst_n    (rst_n),
    .tick_in  (mult_tick),
    .sel      (`HFO_DIV2),
    .tick_out (mult_half_tick)
  );

  // clock source muxes, both outputs registered to stay glitch free
  reg next_core;
  reg next_usb;

  always @* begin
    case (core_src)
      `HFO_CORE_LF:    next_core = lf_tick;
      `HFO_CORE_EXT:   next_core = ext_tick;
      `HFO_CORE_MULT2: next_core = mult_half_tick;
      default:         next_core = hf_div_tick;
    endcase
  end

  always @* begin
    case (usb_src)
      `HFO_USB_EXT:  next_usb = ext_tick;
      `HFO_USB_MULT: next_usb = mult_tick;
      default:       next_usb = hf_tick;
    endcase
  end

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CORE_CLK_EN <= 1'b0;
      USB_CLK_EN  <= 1'b0;
      HF_OSC_RUN  <= 1'b0;
    end else begin
      CORE_CLK_EN <= next_core;
      USB_CLK_EN  <= next_usb;
      HF_OSC_RUN  <= osc_on;
    end
  end

  // read port, data valid only in the cycle after the strobe
  reg [7:0] next_rd;

  always @* begin
    next_rd = 8'h00;
    case (ADDR)
      `HFO_ADDR_CTRL: begin
        next_rd[`HFO_CTRL_EN]                       = osc_en;
        next_rd[`HFO_CTRL_RDY]                      = (state == ST_RUN);
        next_rd[`HFO_CTRL_SUSP]                     = (state == ST_SUSP);
        next_rd[`HFO_CTRL_DIV_HI:`HFO_CTRL_DIV_LO] = div_sel;
      end
      `HFO_ADDR_TRIM: begin
        next_rd[`HFO_TRIM_W-1:0] = trim;
      end
      `HFO_ADDR_CSEL: begin
        next_rd[`HFO_CSEL_CORE_HI:`HFO_CSEL_CORE_LO] = core_src;
        next_rd[`HFO_CSEL_USB_HI:`HFO_CSEL_USB_LO]   = usb_src;
      end
      default: begin
        next_rd = 8'h00;
      end
    endcase
  end

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RD_DATA <= 8'h00;
    end else if (RD_EN) begin
      RD_DATA <= next_rd;
    end else begin
      RD_DATA <= 8'h00;
    end
  end

endmodule

// ===== core/hfo_consts.vh
`ifndef HFO_CONSTS_VH
`define HFO_CONSTS_VH

// register byte addresses
`define HFO_ADDR_CTRL   8'hb2
`define HFO_ADDR_TRIM   8'hb3
`define HFO_ADDR_CSEL   8'hb4

// hf_osc_control fields
`define HFO_CTRL_RESET  8'h80
`define HFO_CTRL_EN     7
`define HFO_CTRL_RDY    6
`define HFO_CTRL_SUSP   5
`define HFO_CTRL_DIV_HI 1
`define HFO_CTRL_DIV_LO 0

// core_clock_divide_sel codes
`define HFO_DIV8        2'h0
`define HFO_DIV4        2'h1
`define HFO_DIV2        2'h2
`define HFO_DIV1        2'h3

// trim register
`define HFO_TRIM_W      5
`define HFO_TRIM_RESET  5'h10

// clock source select register fields
`define HFO_CSEL_CORE_HI 1
`define HFO_CSEL_CORE_LO 0
`define HFO_CSEL_USB_HI  3
`define HFO_CSEL_USB_LO  2
`define HFO_CSEL_RESET   4'h0
`define HFO_CORE_HF      2'h0
`define HFO_CORE_LF      2'h1
`define HFO_CORE_EXT     2'h2
`define HFO_CORE_MULT2   2'h3
`define HFO_USB_HF       2'h0
`define HFO_USB_EXT      2'h1
`define HFO_USB_MULT     2'h2

// oscillator settling time after start, restart or retrim
`define HFO_SETTLE_NS    640
`define HFO_CLK_NS       40

`endif

// ===== core/hfo_sync.v
`timescale 1ns/100ps
module hfo_sync (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // level in and out
  input  wire din,
  output reg  dout
);

  reg meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ===== core/hfo_divider.v
`timescale 1ns/100ps
`include "hfo_consts.vh"
module hfo_divider (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // tick in, divide code, tick out
  input  wire       tick_in,
  input  wire [1:0] sel,
  output reg        tick_out
);

  reg [2:0] cnt;
  reg [2:0] limit;

  always @* begin
    case (sel)
      `HFO_DIV8: limit = 3'h7;
      `HFO_DIV4: limit = 3'h3;
      `HFO_DIV2: limit = 3'h1;
      default:   limit = 3'h0;
    endcase
  end

  // a shrinking divide code wraps the count at once, no long stall
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 3'h0;
      tick_out <= 1'b0;
    end else if (tick_in) begin
      if (cnt >= limit) begin
        cnt      <= 3'h0;
        tick_out <= 1'b1;
      end else begin
        cnt      <= cnt + 3'h1;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule

// ===== sim/hfo_clock_select_checker.sv
`timescale 1ns/100ps
module hfo_clock_select_checker (
  // clock and reset
  input wire       CLK,
  input wire       RST_N,
  // register port
  input wire [7:0] ADDR,
  input wire [7:0] WR_DATA,
  input wire       WR_EN,
  input wire       RD_EN,
  input wire [7:0] RD_DATA,
  // sources and wake
  input wire       LF_OSC_IN,
  input wire       EXT_OSC_IN,
  input wire       MULT_IN,
  input wire       USB_RESUME,
  input wire       VBUS,
  input wire       VBUS_POLARITY_SEL,
  // outputs
  input wire       CORE_CLK_EN,
  input wire       USB_CLK_EN,
  input wire       HF_OSC_RUN
);
  reg  [3:0] age;
  reg        en;
  reg  [1:0] src;
  // no wake source active, so a stopped oscillator must stay stopped
  wire       quiet = !USB_RESUME && (VBUS != VBUS_POLARITY_SEL);
  wire       wctl  = WR_EN && (ADDR == 8'hb2);
  // age masks the start-up settle, which raises the run flag with no write
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      age <= 4'h0;
      en  <= 1'b1;
      src <= 2'h0;
    end else begin
      if (age != 4'hf) age <= age + 4'h1;
      if (wctl) en <= WR_DATA[7];
      if (WR_EN && ADDR == 8'hb4) src <= WR_DATA[1:0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  rd_idle_zero_a: assert property (!$past(RD_EN) |-> RD_DATA == 8'h00)
    else $error("read data not zero outside read");
  ctrl_unused_a: assert property ($past(RD_EN) && $past(ADDR) == 8'hb2 |-> RD_DATA[4:2] == 3'h0)
    else $error("control unused bits not zero");
  ready_run_a: assert property ($past(RD_EN) && $past(ADDR) == 8'hb2 && RD_DATA[6]
    |-> HF_OSC_RUN || $past(HF_OSC_RUN))
    else $error("ready read while oscillator stopped");
  susp_stop_a: assert property (age == 4'hf && wctl && WR_DATA[7:5] == 3'h5 && quiet
    && $past(quiet, 4) |-> ##2 !HF_OSC_RUN)
    else $error("suspend write did not stop oscillator");
  off_stop_a: assert property (wctl && !WR_DATA[7] |-> ##2 !HF_OSC_RUN [*2])
    else $error("disable write did not stop oscillator");
  stay_stop_a: assert property (age == 4'hf && !HF_OSC_RUN && !WR_EN && !$past(WR_EN) && quiet
    && $past(quiet) && $past(quiet, 2) && $past(quiet, 3) && $past(quiet, 4) |=> !HF_OSC_RUN)
    else $error("oscillator restarted without wake");
  wake_run_a: assert property (age == 4'hf && en && !HF_OSC_RUN && !quiet && !WR_EN
    |-> ##[1:8] HF_OSC_RUN)
    else $error("wake did not restart oscillator");
  core_gate_a: assert property (src == 2'h0 && $past(src, 3) == 2'h0 && !HF_OSC_RUN
    && !$past(HF_OSC_RUN) && !$past(HF_OSC_RUN, 2) && !$past(HF_OSC_RUN, 3)
    |-> !CORE_CLK_EN)
    else $error("core clock pulse with oscillator stopped");
  cover property (wctl && WR_DATA[5]);
  cover property ($rose(HF_OSC_RUN) && age == 4'hf);
  cover property (CORE_CLK_EN && src == 2'h1);
endmodule

bind hfo_clock_select hfo_clock_select_checker u_hfo_clock_select_checker (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
  .RD_DATA(RD_DATA), .LF_OSC_IN(LF_OSC_IN), .EXT_OSC_IN(EXT_OSC_IN), .MULT_IN(MULT_IN),
  .USB_RESUME(USB_RESUME), .VBUS(VBUS), .VBUS_POLARITY_SEL(VBUS_POLARITY_SEL),
  .CORE_CLK_EN(CORE_CLK_EN), .USB_CLK_EN(USB_CLK_EN), .HF_OSC_RUN(HF_OSC_RUN));

// ===== sim/hfo_clock_select_tb.sv
`timescale 1ns/100ps
`include "hfo_consts.vh"
`define CHK(g, e) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
  n_errors = n_errors + 1; \
  $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module hfo_clock_select_tb;
  reg        CLK = 0, RST_N = 0, WR_EN = 0, RD_EN = 0, rd_d = 0;
  reg  [7:0] ADDR = 0, WR_DATA = 0, ev, r;
  reg        LF_OSC_IN = 0, EXT_OSC_IN = 0, MULT_IN = 0, USB_RESUME = 0, VBUS = 0;
  reg        VBUS_POLARITY_SEL = 1;
  wire [7:0] RD_DATA;
  wire       CORE_CLK_EN, USB_CLK_EN, HF_OSC_RUN;
  integer    n_errors = 0, total_checks = 0, n_core = 0, n_usb = 0, ph = 0, i, c0, u0;
  reg  [7:0] exp_q[$];
  always #20 CLK = ~CLK;
  hfo_clock_select #(.SETTLE_NS(640)) u_hfo_clock_select (.CLK(CLK), .RST_N(RST_N),
    .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .LF_OSC_IN(LF_OSC_IN), .EXT_OSC_IN(EXT_OSC_IN), .MULT_IN(MULT_IN),
    .USB_RESUME(USB_RESUME), .VBUS(VBUS), .VBUS_POLARITY_SEL(VBUS_POLARITY_SEL),
    .CORE_CLK_EN(CORE_CLK_EN), .USB_CLK_EN(USB_CLK_EN), .HF_OSC_RUN(HF_OSC_RUN));
  // source pins: lf period 8, ext 6, mult 4 cycles, so 48-cycle windows count exactly
  always @(posedge CLK) begin
    ph <= ph + 1;
    if (ph % 4 == 3) LF_OSC_IN <= ~LF_OSC_IN;
    if (ph % 3 == 2) EXT_OSC_IN <= ~EXT_OSC_IN;
    if (ph % 2 == 1) MULT_IN <= ~MULT_IN;
    n_core <= n_core + CORE_CLK_EN;
    n_usb <= n_usb + USB_CLK_EN;
    if (rd_d) begin
      ev = exp_q.pop_front();
      `CHK(RD_DATA, ev)
    end
    rd_d <= RD_EN;
  end
  task wr(input [7:0] a, input [7:0] d); begin
    WR_EN <= 1;
    RD_EN <= 0;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge CLK);
  end endtask
  task rd(input [7:0] a, input [7:0] e); begin
    RD_EN <= 1;
    WR_EN <= 0;
    ADDR <= a;
    exp_q.push_back(e);
    @(posedge CLK);
  end endtask
  // both strobes are lowered here, and wr and rd each lower the other one, so back-to-back calls never raise both
  task idle(input integer n); begin
    WR_EN <= 0;
    RD_EN <= 0;
    repeat (n) @(posedge CLK);
  end endtask
  task cnt(input integer w, input integer ec, input integer eu); begin
    idle(8);
    c0 = n_core;
    u0 = n_usb;
    repeat (w) @(posedge CLK);
    `CHK(n_core - c0, ec)
    `CHK(n_usb - u0, eu)
  end endtask
  task endt(input string nm); begin
    $display("test %s done, errors so far %0d", nm, n_errors);
  end endtask
  task print_verdict; begin
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end endtask
  initial begin
    #400000;
    n_errors = n_errors + 1;
    print_verdict;
  end
  initial begin
    r = $urandom(48);
    repeat (12) @(posedge CLK);
    RST_N <= 1;
    idle(3);
    rd(8'hb2, 8'h80);
    rd(8'hb3, 8'h10);
    rd(8'hb4, 8'h00);
    idle(30);
    rd(8'hb2, 8'hc0);
    endt("reset");
    r = $urandom;
    wr(8'hb3, r);
    rd(8'hb3, {3'h0, r[4:0]});
    rd(8'hb2, 8'h80);
    wr(8'hb3, 8'he0);
    wr(8'hb2, 8'h9f);
    idle(30);
    rd(8'hb2, 8'hc3);
    endt("trim");
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'hb2, 8'h80 | i);
      cnt(64, 8 << i, 64);
    end
    endt("divide");
    wr(8'hb4, 8'hf1);
    rd(8'hb4, 8'h01);
    cnt(48, 6, 48);
    wr(8'hb4, 8'h06);
    cnt(48, 8, 8);
    wr(8'hb4, 8'h0b);
    cnt(48, 6, 12);
    wr(8'hb4, 8'h0c);
    cnt(48, 48, 48);
    endt("source");
    // two wake rounds, each taking a randomly picked wake source
    for (i = 0; i < 2; i = i + 1) begin
      r = $urandom;
      wr(8'hb2, 8'ha3);
      idle(3);
      rd(8'hb2, 8'ha3);
      cnt(20, 0, 0);
      if (r[0] ^ i[0]) USB_RESUME <= 1;
      else VBUS_POLARITY_SEL <= 0;
      idle(30);
      rd(8'hb2, 8'hc3);
      USB_RESUME <= 0;
      VBUS_POLARITY_SEL <= 1;
      idle(5);
    end
    endt("suspend");
    wr(8'hb2, 8'h03);
    idle(3);
    rd(8'hb2, 8'h03);
    cnt(20, 0, 0);
    wr(8'hb2, 8'h83);
    idle(30);
    rd(8'hb2, 8'hc3);
    endt("enable");
    r = $urandom;
    wr(8'h55, r);
    rd(8'h55, 8'h00);
    rd(8'hb2, 8'hc3);
    rd(8'hb3, 8'h00);
    idle(2);
    endt("unmapped");
    print_verdict;
  end
endmodule
